// ===== coc_defines.vh
`ifndef COC_DEFINES_VH
`define COC_DEFINES_VH
// comparator instances sharing one idle group
`define COC_NCMP 2
// apb register byte offsets
`define COC_OFF_CTRL0 8'h00
`define COC_OFF_CTRL1 8'h04
`define COC_OFF_STATE 8'h08
`define COC_OFF_ISTAT 8'h0C
`define COC_OFF_IMASK 8'h10
`define COC_OFF_FCLR 8'h14
`define COC_ADDR_W 8
// comparator_control_register fields
`define COC_B_EN 0
`define COC_B_INV 1
`define COC_B_FLT 2
`define COC_B_FCLK 3
`define COC_B_SIDL 4
`define COC_B_ROE 5
`define COC_B_GAIN 6
`define COC_F_RNG_LO 7
`define COC_F_RNG_HI 8
`define COC_F_DAC_LO 16
`define COC_F_DAC_HI 25
`define COC_CTRL_MASK 32'h03FF01FF
`define COC_CTRL_RST 32'h00000000
// reference range codes
`define COC_RNG_HALF_SUPPLY 2'h0
`define COC_RNG_INTERNAL 2'h1
`define COC_RNG_EXTERNAL 2'h2
// interrupt status layout: bits 0..1 trip, bits 2..3 fault latch
`define COC_ST_TRIP_LO 0
`define COC_ST_FAULT_LO 2
`define COC_ST_W 4
// timing: stretcher minimum width and filter stable count
`define COC_STRETCH_CYCLES 2'h3
`define COC_FILT_STABLE 2'h3
`define COC_ONE2 2'h1
`define COC_ZERO2 2'h0
`define COC_ZERO32 32'h00000000
`endif

// ===== coc_conditioner.v
`timescale 1ns/1ps
`include "coc_defines.vh"

module coc_conditioner (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [1:0] comparator_pin,
	input wire filter_clock_pin,
	input wire sleep_mode,
	input wire idle_mode,
	output wire [1:0] comparator_out,
	output wire [1:0] adc_trigger,
	output wire [1:0] pwm_current_limit,
	output wire [1:0] pwm_current_minimum,
	output wire [1:0] pwm_fault_disable,
	output wire [1:0] comparator_enable,
	output wire [1:0] reference_output_enable,
	output wire [1:0] buffer_gain_select,
	output wire [3:0] reference_range_select,
	output wire [19:0] dac_level,
	output wire comparator_clock_gate,
	output wire wake_request,
	output wire irq
);

	////////////////////////////////////////////////////////////////////////////////
	// register storage
	reg [31:0] ctrl_mem [0:`COC_NCMP-1]; // comparator_control_register per comparator
	reg [`COC_ST_W-1:0] istat_reg; // sticky event bits
	reg [`COC_ST_W-1:0] imask_reg; // interrupt mask, same layout
	reg [31:0] prdata_reg; // registered read data
	reg pready_reg; // one wait state per access
	reg pslverr_reg; // unmapped address answer
	reg irq_reg; // level interrupt
	reg wake_reg; // sleep/idle wake request
	reg gate_reg; // logic clock gate indication
	// synchronisers and pipeline
	reg [1:0] cmp_sync1_reg; // first stage, read only by second
	reg [1:0] cmp_sync2_reg;
	reg fclk_sync1_reg; // first stage, read only by second
	reg fclk_sync2_reg;
	reg fclk_prev_reg; // edge detect on synced filter clock
	reg [1:0] stretch_reg; // stretched comparator result
	reg [1:0] filt_reg; // filter output level
	reg [1:0] out_reg; // conditioned result
	reg [1:0] out_prev_reg; // previous conditioned result for edges
	reg [1:0] trig_reg; // adc trigger pulses
	reg [1:0] fault_reg; // latched pwm disable
	reg [1:0] fault_clr_pulse; // software fault clear strobe
	// stretch and filter counters are kept per comparator inside the generate loop
	wire access_w; // completing access phase
	wire idle_stop_w; // idle group shutdown
	wire filt_tick_ext_w; // rising edge of external filter clock
	wire [1:0] active_w; // comparator allowed to run
	wire [1:0] trip_w; // rising edge of conditioned result
	wire [1:0] fault_set_w; // new fault events

	////////////////////////////////////////////////////////////////////////////////
	// decode helper, used for every register
	function hit;
		input [31:0] addr;
		input [`COC_ADDR_W-1:0] off;
		begin
			hit = (addr[`COC_ADDR_W-1:0] == off) && (addr[31:`COC_ADDR_W] == 24'h000000);
		end
	endfunction

	assign access_w = psel & penable & pready_reg;
	// any stop-when-idle bit takes the whole group down while idle
	assign idle_stop_w = idle_mode & (ctrl_mem[0][`COC_B_SIDL] | ctrl_mem[1][`COC_B_SIDL]);
	assign filt_tick_ext_w = fclk_sync2_reg & ~fclk_prev_reg;
	assign trip_w = out_reg & ~out_prev_reg;

	////////////////////////////////////////////////////////////////////////////////
	// apb slave: setup, then one wait state, then completion
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= `COC_ZERO32;
		end else begin
			// ready rises after the first access cycle, drops after completion
			pready_reg <= psel & penable & ~pready_reg;
			if (psel & penable & ~pready_reg) begin
				pslverr_reg <= ~(hit(paddr, `COC_OFF_CTRL0) | hit(paddr, `COC_OFF_CTRL1) |
					hit(paddr, `COC_OFF_STATE) | hit(paddr, `COC_OFF_ISTAT) |
					hit(paddr, `COC_OFF_IMASK) | hit(paddr, `COC_OFF_FCLR));
				// read mux, unmapped reads return zero
				if (hit(paddr, `COC_OFF_CTRL0))
					prdata_reg <= ctrl_mem[0];
				else if (hit(paddr, `COC_OFF_CTRL1))
					prdata_reg <= ctrl_mem[1];
				else if (hit(paddr, `COC_OFF_STATE))
					prdata_reg <= {24'h000000, fault_reg, stretch_reg, filt_reg, out_reg};
				else if (hit(paddr, `COC_OFF_ISTAT))
					prdata_reg <= {28'h0000000, istat_reg};
				else if (hit(paddr, `COC_OFF_IMASK))
					prdata_reg <= {28'h0000000, imask_reg};
				else
					prdata_reg <= `COC_ZERO32;
			end else begin
				pslverr_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control, mask and fault clear writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_mem[0] <= `COC_CTRL_RST;
			ctrl_mem[1] <= `COC_CTRL_RST;
			imask_reg <= 4'h0;
			fault_clr_pulse <= 2'h0;
		end else begin
			fault_clr_pulse <= 2'h0;
			if (access_w & pwrite) begin
				// reserved bits never stored, so they read as zero
				if (hit(paddr, `COC_OFF_CTRL0))
					ctrl_mem[0] <= pwdata & `COC_CTRL_MASK;
				if (hit(paddr, `COC_OFF_CTRL1))
					ctrl_mem[1] <= pwdata & `COC_CTRL_MASK;
				if (hit(paddr, `COC_OFF_IMASK))
					imask_reg <= pwdata[`COC_ST_W-1:0];
				if (hit(paddr, `COC_OFF_FCLR))
					fault_clr_pulse <= pwdata[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky status: write one clears, a new event wins over the clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_reg <= 4'h0;
		end else begin
			if (access_w & pwrite & hit(paddr, `COC_OFF_ISTAT))
				istat_reg <= (istat_reg & ~pwdata[`COC_ST_W-1:0]) | {fault_set_w, trip_w};
			else
				istat_reg <= istat_reg | {fault_set_w, trip_w};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and filter clock edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_sync1_reg <= 2'h0;
			cmp_sync2_reg <= 2'h0;
			fclk_sync1_reg <= 1'b0;
			fclk_sync2_reg <= 1'b0;
			fclk_prev_reg <= 1'b0;
		end else begin
			cmp_sync1_reg <= comparator_pin;
			cmp_sync2_reg <= cmp_sync1_reg;
			fclk_sync1_reg <= filter_clock_pin;
			fclk_sync2_reg <= fclk_sync1_reg;
			fclk_prev_reg <= fclk_sync2_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per comparator chain: polarity, stretcher, filter, consumers
	genvar gi;
	generate
		for (gi = 0; gi < `COC_NCMP; gi = gi + 1) begin : g_cmp
			reg [1:0] str_cnt_reg; // remaining stretch cycles
			reg [1:0] flt_cnt_reg; // stable samples of a new level
			wire pol_w; // polarity applied result
			wire tick_w; // filter sample instant
			wire bypass_w; // filter skipped
			wire cond_w; // conditioned level before output flop

			assign active_w[gi] = ctrl_mem[gi][`COC_B_EN] & ~idle_stop_w;
			// invert before the stretcher so the minimum width applies to the chosen sense
			assign pol_w = (cmp_sync2_reg[gi] ^ ctrl_mem[gi][`COC_B_INV]) & active_w[gi];
			// system clock samples every cycle, external clock on its rising edge
			assign tick_w = ctrl_mem[gi][`COC_B_FCLK] ? filt_tick_ext_w : 1'b1;
			assign bypass_w = ~ctrl_mem[gi][`COC_B_FLT] | sleep_mode;
			// sleep path skips the clocked filter so a trip still reaches the interrupt
			assign cond_w = sleep_mode ? stretch_reg[gi] : filt_reg[gi];
			assign fault_set_w[gi] = trip_w[gi] & ~fault_reg[gi];

			// stretcher: held high for at least three system clocks after any pulse
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					str_cnt_reg <= `COC_ZERO2;
					stretch_reg[gi] <= 1'b0;
				end else begin
					if (pol_w)
						str_cnt_reg <= `COC_STRETCH_CYCLES - `COC_ONE2;
					else if (str_cnt_reg != `COC_ZERO2)
						str_cnt_reg <= str_cnt_reg - `COC_ONE2;
					stretch_reg[gi] <= pol_w | (str_cnt_reg != `COC_ZERO2);
				end
			end

			// glitch filter: a new level must be seen on three successive samples
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flt_cnt_reg <= `COC_ZERO2;
					filt_reg[gi] <= 1'b0;
				end else if (bypass_w) begin
					// disabled filter forwards the stretched signal
					flt_cnt_reg <= `COC_ZERO2;
					filt_reg[gi] <= stretch_reg[gi];
				end else if (tick_w) begin
					if (stretch_reg[gi] == filt_reg[gi]) begin
						// same level as output: restart count
						flt_cnt_reg <= `COC_ZERO2;
					end else if (flt_cnt_reg == `COC_FILT_STABLE - `COC_ONE2) begin
						flt_cnt_reg <= `COC_ZERO2;
						filt_reg[gi] <= stretch_reg[gi];
					end else begin
						flt_cnt_reg <= flt_cnt_reg + `COC_ONE2;
					end
				end
			end

			// consumers: the output flop takes the conditioned level, trigger and fault follow its rising edge a cycle later
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					out_reg[gi] <= 1'b0;
					out_prev_reg[gi] <= 1'b0;
					trig_reg[gi] <= 1'b0;
					fault_reg[gi] <= 1'b0;
				end else begin
					out_reg[gi] <= cond_w;
					out_prev_reg[gi] <= out_reg[gi];
					trig_reg[gi] <= trip_w[gi];
					// latch holds until software clears; a trip in the clear cycle wins
					if (trip_w[gi])
						fault_reg[gi] <= 1'b1;
					else if (fault_clr_pulse[gi])
						fault_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// interrupt, wake and clock gate indication
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			gate_reg <= 1'b0;
		end else begin
			irq_reg <= |(istat_reg & imask_reg);
			// a trip while sleeping or idle asks the system to wake
			wake_reg <= (sleep_mode | idle_mode) & |(stretch_reg & active_w);
			// logic clocks gated in sleep; analog parts may keep running
			gate_reg <= sleep_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops except comparator_enable, which idle_mode gates directly
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;
	assign wake_request = wake_reg;
	assign comparator_clock_gate = gate_reg;
	assign comparator_out = out_reg;
	assign adc_trigger = trig_reg;
	// current limit truncates pulse, current minimum truncates period, both level driven
	assign pwm_current_limit = out_reg;
	assign pwm_current_minimum = out_reg;
	assign pwm_fault_disable = fault_reg;
	assign comparator_enable = active_w;
	// single reference output enable per comparator; exclusivity is software's duty
	assign reference_output_enable = {ctrl_mem[1][`COC_B_ROE], ctrl_mem[0][`COC_B_ROE]};
	assign buffer_gain_select = {ctrl_mem[1][`COC_B_GAIN], ctrl_mem[0][`COC_B_GAIN]};
	assign reference_range_select = {ctrl_mem[1][`COC_F_RNG_HI:`COC_F_RNG_LO],
		ctrl_mem[0][`COC_F_RNG_HI:`COC_F_RNG_LO]};
	assign dac_level = {ctrl_mem[1][`COC_F_DAC_HI:`COC_F_DAC_LO], ctrl_mem[0][`COC_F_DAC_HI:`COC_F_DAC_LO]};

endmodule // coc_conditioner

// ===== coc_conditioner_sva.sv
`timescale 1ns/1ps
// port checks for the comparator conditioner
module coc_conditioner_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire pready,
	input wire pslverr,
	input wire sleep_mode,
	input wire idle_mode,
	input wire [1:0] comparator_out,
	input wire [1:0] adc_trigger,
	input wire [1:0] pwm_current_limit,
	input wire [1:0] pwm_current_minimum,
	input wire [1:0] pwm_fault_disable,
	input wire comparator_clock_gate,
	input wire wake_request
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// apb setup then exactly one wait state
	sequence s_setup; psel && !penable; endsequence
	sequence s_wait; psel && penable && !pready; endsequence
	property p_apb_wait; s_setup ##1 s_wait |=> pready; endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("pready late");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
	property p_slverr; pslverr |-> pready; endproperty
	a_slverr: assert property (p_slverr) else $error("pslverr alone");
	// pwm consumers see the conditioned level itself
	property p_pwm; pwm_current_limit == comparator_out && pwm_current_minimum == comparator_out; endproperty
	a_pwm: assert property (p_pwm) else $error("pwm path differs");
	// one trigger pulse per rising edge of the result
	property p_adc; $rose(comparator_out[0]) |=> adc_trigger[0] ##1 !adc_trigger[0]; endproperty
	a_adc: assert property (p_adc) else $error("adc trigger wrong");
	property p_stretch; $rose(comparator_out[0]) |-> comparator_out[0] [*3]; endproperty
	a_stretch: assert property (p_stretch) else $error("pulse too short");
	property p_gate; comparator_clock_gate == $past(sleep_mode); endproperty
	a_gate: assert property (p_gate) else $error("clock gate wrong");
	property p_wake; wake_request |-> $past(sleep_mode || idle_mode); endproperty
	a_wake: assert property (p_wake) else $error("wake while running");
	// fault latch: only a clear write may drop it, and the clear lands two cycles after the write completes
	property p_fault; pwm_fault_disable[0] && !$past(pready && pwrite) |=> pwm_fault_disable[0]; endproperty
	a_fault: assert property (p_fault) else $error("fault latch lost");
endmodule // coc_conditioner_chk

bind coc_conditioner coc_conditioner_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
	.sleep_mode, .idle_mode, .comparator_out, .adc_trigger, .pwm_current_limit, .pwm_current_minimum,
	.pwm_fault_disable, .comparator_clock_gate, .wake_request);

// ===== coc_far_model.sv
`timescale 1ns/1ps
// far side: comparator result and a slow filter clock
module coc_far_model (
	input wire pclk,
	input wire [1:0] drive,
	input wire fclk_on,
	output reg [1:0] comparator_pin = 2'h0,
	output reg filter_clock_pin = 1'b0
);
	reg [1:0] div_reg = 2'h0; // quarter-rate divider
	// clock stands still while fclk_on is low
	always @(posedge pclk) begin
		comparator_pin <= drive;
		if (fclk_on) begin
			div_reg <= div_reg + 2'h1;
		end
		filter_clock_pin <= div_reg[1];
	end
endmodule // coc_far_model

// ===== coc_conditioner_tb.sv
`timescale 1ns/1ps
`include "coc_defines.vh"
module coc_conditioner_tb;
	reg pclk, presetn, psel, penable, pwrite, sleep_mode, idle_mode, fclk_on;
	reg [31:0] paddr, pwdata, d;
	reg [1:0] drive;
	wire [31:0] prdata;
	wire pready, pslverr, filter_clock_pin, comparator_clock_gate, wake_request, irq;
	wire [1:0] comparator_pin, comparator_out, adc_trigger, pwm_current_limit, pwm_current_minimum;
	wire [1:0] pwm_fault_disable, comparator_enable, reference_output_enable, buffer_gain_select;
	wire [3:0] reference_range_select;
	wire [19:0] dac_level;
	integer error_cnt = 0, samples_checked = 0, seed = 32, i, hi, trg, lat;
	reg [32:0] exp_q[$]; // expected {pslverr, prdata} per read
	coc_conditioner dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .comparator_pin, .filter_clock_pin, .sleep_mode, .idle_mode, .comparator_out, .adc_trigger,
		.pwm_current_limit, .pwm_current_minimum, .pwm_fault_disable, .comparator_enable,
		.reference_output_enable, .buffer_gain_select, .reference_range_select, .dac_level,
		.comparator_clock_gate, .wake_request, .irq);
	coc_far_model u_far (.pclk, .drive, .fclk_on, .comparator_pin, .filter_clock_pin);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task chk(input string nm, input [32:0] seen, input [32:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// apb transfer held until pready is sampled high; only the watchdog ends a hang
	task apb(input w, input [31:0] a, input [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		{psel, penable} <= 2'h0;
	endtask
	task rd(input [31:0] a, input [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, `COC_ZERO32);
	endtask
	// monitor: oldest note against each completed read
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			chk("read", {pslverr, prdata}, exp_q.pop_front());
		end
	end
	task wt(input integer n);
		repeat (n) @(posedge pclk);
	endtask
	// one-cycle pulse on comparator 0, then count result, trigger and cycles before the result rises
	task pulse;
		drive <= 2'h1;
		@(posedge pclk);
		drive <= 2'h0;
		{hi, trg, lat} = 96'h0;
		repeat (20) begin
			@(posedge pclk);
			lat = lat + (hi == 0 && comparator_out[0] == 1'b0);
			hi = hi + comparator_out[0];
			trg = trg + adc_trigger[0];
		end
	endtask
	// watchdog far beyond the expected run
	initial begin
		#2000000;
		error_cnt = error_cnt + 1;
		test_done;
	end
	initial begin
		{presetn, psel, penable, pwrite, sleep_mode, idle_mode, fclk_on, drive} = 9'h000;
		{paddr, pwdata} = 64'h0;
		wt(3);
		presetn <= 1'b1;
		rd(`COC_OFF_CTRL0, 33'h0);
		rd(`COC_OFF_ISTAT, 33'h0);
		rd(32'h00000018, {1'b1, `COC_ZERO32}); // unmapped
		apb(1'b1, `COC_OFF_CTRL1, 32'hFFFFFFDE);
		rd(`COC_OFF_CTRL1, {1'b0, 32'hFFFFFFDE & `COC_CTRL_MASK});
		chk("gain", buffer_gain_select[1], 1'b1);
		// each range code, random level, output enable on one comparator only
		for (i = 0; i < 3; i = i + 1) begin
			d = (($random(seed) & 32'h3FF) << 16) | (i << 7) | 32'h60;
			apb(1'b1, `COC_OFF_CTRL0, d);
			rd(`COC_OFF_CTRL0, {1'b0, d});
			chk("range", reference_range_select[1:0], i[1:0]);
			chk("level", dac_level[9:0], d[25:16]);
			chk("ref out", reference_output_enable, 2'h1);
			chk("gain both", buffer_gain_select, 2'h3);
		end
		apb(1'b1, `COC_OFF_CTRL0, 32'h1);
		pulse;
		chk("width", hi, 3);
		chk("latency", lat, 5);
		chk("trigger", trg, 1);
		chk("fault", pwm_fault_disable, 2'h1);
		rd(`COC_OFF_ISTAT, 33'h5);
		apb(1'b1, `COC_OFF_IMASK, 32'h1);
		wt(3);
		chk("irq", irq, 1'b1);
		apb(1'b1, `COC_OFF_ISTAT, 32'h5);
		apb(1'b1, `COC_OFF_FCLR, 32'h1);
		wt(3);
		chk("irq clear", irq, 1'b0);
		chk("fault clear", pwm_fault_disable, 2'h0);
		apb(1'b1, `COC_OFF_CTRL0, 32'h5);
		pulse;
		chk("filtered", hi, 3);
		chk("filter delay", lat, 7);
		apb(1'b1, `COC_OFF_CTRL0, 32'h3);
		wt(8);
		chk("inverted", comparator_out[0], 1'b1);
		// slow filter clock: settle low, stop it, then let it run
		apb(1'b1, `COC_OFF_CTRL0, 32'hD);
		fclk_on <= 1'b1;
		wt(40);
		{fclk_on, drive} <= 3'h1;
		wt(20);
		chk("clock held", comparator_out[0], 1'b0);
		fclk_on <= 1'b1;
		wt(40);
		chk("clock runs", comparator_out[0], 1'b1);
		drive <= 2'h0;
		wt(40);
		apb(1'b1, `COC_OFF_ISTAT, 32'hF);
		// sleep with the filter clock stopped: bypass still trips
		{sleep_mode, fclk_on, drive} <= 4'h9;
		wt(12);
		chk("gate", comparator_clock_gate, 1'b1);
		chk("wake", wake_request, 1'b1);
		chk("sleep irq", irq, 1'b1);
		{sleep_mode, drive} <= 3'h0;
		apb(1'b1, `COC_OFF_CTRL1, 32'h11);
		idle_mode <= 1'b1;
		wt(2);
		chk("idle stop", comparator_enable, 2'h0);
		idle_mode <= 1'b0;
		wt(2);
		chk("idle end", comparator_enable, 2'h3);
		chk("pending", exp_q.size(), 0);
		test_done;
	end
endmodule // coc_conditioner_tb
